// >>> src/spu_regs.svh
// Purpose: Addresses, bit positions, reset values and counts of the serial port.
// Assumes: Included by bare name.
// Notes: The clock is the fundamental oscillator.
`ifndef SPU_REGS_SVH
`define SPU_REGS_SVH
`define SPU_CTL_ADR   8'h98
`define SPU_BUF_ADR   8'h99
`define SPU_T2C_ADR   8'hC8
`define SPU_PWR_ADR   8'h87
`define SPU_IOC_ADR   8'hF8
`define SPU_CTL_BITS  5'h13
`define SPU_TXSEL_BA  8'hCC
`define SPU_RXSEL_BA  8'hCD
`define SPU_ERR_BA    8'hFD
`define SPU_TXSEL_POS 4
`define SPU_RXSEL_POS 5
`define SPU_DBL_POS   7
`define SPU_ERR_POS   5
`define SPU_CTL_RST   8'h00
`define SPU_M0_LAST   4'hB
`define SPU_M0_HALF   4'h6
`define SPU_M0_SAMP   4'h5
`define SPU_M0_BITS   4'h8
`define SPU_OVS_LAST  4'hF
`define SPU_VOTE_LO   4'h7
`define SPU_VOTE_HI   4'h9
`define SPU_VOTE_CHK  4'hA
`endif

// >>> src/spu_pkg.sv
// Purpose: Types of the serial port.
// Assumes: Nothing.
// Notes: One packed struct holds all state of the top module except the transmit word buffer.
package spu_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_RUN = 2'b01} spu_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_ASYNC = 2'b01, RX_SHIFT = 2'b11} spu_rx_st_t;
  typedef struct packed {
    logic sm_hi;
    logic sm_lo;
    logic mp;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } spu_ctl_t;
  typedef struct packed {
    spu_ctl_t   sc;
    logic [7:0] rbuf;
    logic       tx_clock_select;
    logic       rclk;
    logic       rate_double;
    logic       serial_error_flag;
    logic [7:0] rdata;
    logic       irq;
    logic       txd;
    logic       rxd_o;
    logic       rxd_oe;
    logic [1:0] pre;
    logic       half;
    logic [2:0] sync;
    spu_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_n;
    logic [3:0] tx_c;
    logic       tx_b8;
    spu_rx_st_t rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_n;
    logic [3:0] rx_c;
    logic [2:0] rx_v;
  } spu_st_t;
endpackage

// >>> src/spu_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Ready on the fill side is low only while both entries hold words.
`timescale 1ns/1ps
`default_nettype none
module spu_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
    logic              rdy;
  } spu_buf_t;
  spu_buf_t q;
  spu_buf_t n;
  logic     push;
  logic     pop;

  always_comb
  begin
    n = q;
    push = in_valid && q.rdy;
    pop = out_ready && (q.cnt != 2'h0);
    if (push)
    begin
      n.mem[q.wp] = in_data;
      n.wp = ~q.wp;
    end
    if (pop)
    begin
      n.rp = ~q.rp;
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    n.rdy = (n.cnt != 2'h2);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '{mem: '0, wp: 1'b0, rp: 1'b0, cnt: 2'h0, rdy: 1'b1};
    end
    else
    begin
      q <= n;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = (q.cnt != 2'h0);
  assign out_data = q.mem[q.rp];
endmodule
`default_nettype wire

// >>> src/spu_top.sv
// Purpose: Serial port with shift mode and three asynchronous modes.
// Assumes: clk_sys is the oscillator; timer overflows are one-cycle pulses.
// Notes: Register reads answer one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "spu_regs.svh"
module spu_top (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wr,
  input  wire logic       bit_val,
  input  wire logic       t1_ovf,
  input  wire logic       t2_ovf,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd,
  output logic            serial_irq,
  output logic            tx_ready
);
  spu_pkg::spu_st_t q;
  spu_pkg::spu_st_t n;
  logic       txq_v;
  logic [7:0] txq_d;
  logic       pop;
  logic       ctl_wr;
  logic       err_wr;
  logic       rx_fin;
  logic       rx_bit;
  logic       m0;
  logic       m1;

  function automatic logic vote(input logic [2:0] v);
    vote = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [3:0] last_bit(input logic hi, input logic lo);
    if (!hi && !lo)
    begin
      last_bit = 4'h7;
    end
    else if (!hi)
    begin
      last_bit = 4'h9;
    end
    else
    begin
      last_bit = 4'hA;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Transmit word buffer.

  spu_buf2 #(.W(8)) u_txq (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (sfr_wr && (sfr_addr == `SPU_BUF_ADR)),
    .in_data   (sfr_wdata),
    .in_ready  (tx_ready),
    .out_valid (txq_v),
    .out_data  (txq_d),
    .out_ready (pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  assign m0 = !q.sc.sm_hi && !q.sc.sm_lo;
  assign m1 = !q.sc.sm_hi && q.sc.sm_lo;
  assign ctl_wr = (sfr_wr && (sfr_addr == `SPU_CTL_ADR))
               || (bit_wr && (bit_addr[7:3] == `SPU_CTL_BITS));
  assign err_wr = (sfr_wr && (sfr_addr == `SPU_IOC_ADR))
               || (bit_wr && (bit_addr == `SPU_ERR_BA));
  assign rx_bit = vote(q.rx_v);
  assign pop = txq_v && (q.tx_st == spu_pkg::TX_IDLE)
            && (!m0 || (q.rx_st == spu_pkg::RX_IDLE));

  always_comb
  begin
    logic       ttick;
    logic       rtick;
    logic       t1src;
    logic       rxd;
    logic       acc;
    logic       ti_set;
    logic [7:0] rdat;
    logic       r9;
    ttick = 1'b0;
    rtick = 1'b0;
    t1src = 1'b0;
    rxd = q.sync[1];
    acc = 1'b0;
    ti_set = 1'b0;
    rdat = 8'h00;
    r9 = 1'b0;
    rx_fin = 1'b0;
    n = q;
    n.sync = {q.sync[1], q.sync[0], rxd_in};
    n.pre = q.pre + 2'h1;
    if (t1_ovf)
    begin
      n.half = ~q.half;
    end
    t1src = q.rate_double ? t1_ovf : (t1_ovf && q.half);
    if (q.sc.sm_hi && !q.sc.sm_lo)
    begin
      ttick = q.rate_double ? q.pre[0] : (&q.pre);
      rtick = ttick;
    end
    else
    begin
      ttick = q.tx_clock_select ? t2_ovf : t1src;
      rtick = q.rclk ? t2_ovf : t1src;
    end
    // Register writes, byte and bit.
    if (sfr_wr)
    begin
      case (sfr_addr)
        `SPU_CTL_ADR: n.sc = sfr_wdata;
        `SPU_T2C_ADR:
        begin
          n.tx_clock_select = sfr_wdata[`SPU_TXSEL_POS];
          n.rclk = sfr_wdata[`SPU_RXSEL_POS];
        end
        `SPU_PWR_ADR: n.rate_double = sfr_wdata[`SPU_DBL_POS];
        `SPU_IOC_ADR: n.serial_error_flag = sfr_wdata[`SPU_ERR_POS];
        default: n.rate_double = n.rate_double;
      endcase
    end
    if (bit_wr)
    begin
      if (bit_addr[7:3] == `SPU_CTL_BITS)
      begin
        n.sc[bit_addr[2:0]] = bit_val;
      end
      else if (bit_addr == `SPU_TXSEL_BA)
      begin
        n.tx_clock_select = bit_val;
      end
      else if (bit_addr == `SPU_RXSEL_BA)
      begin
        n.rclk = bit_val;
      end
      else if (bit_addr == `SPU_ERR_BA)
      begin
        n.serial_error_flag = bit_val;
      end
    end
    // Transmitter.
    case (q.tx_st)
      spu_pkg::TX_IDLE:
      begin
        if (pop)
        begin
          n.tx_st = spu_pkg::TX_RUN;
          n.tx_c = 4'h0;
          n.tx_n = 4'h0;
          n.tx_b8 = q.sc.tb8;
          if (m0)
          begin
            n.tx_sh = {3'b111, txq_d};
          end
          else
          begin
            n.tx_sh = {1'b1, m1 | q.sc.tb8, txq_d, 1'b0};
          end
        end
      end
      spu_pkg::TX_RUN:
      begin
        if (m0 || ttick)
        begin
          if (q.tx_c == (m0 ? `SPU_M0_LAST : `SPU_OVS_LAST))
          begin
            n.tx_c = 4'h0;
            n.tx_sh = {1'b1, q.tx_sh[10:1]};
            n.tx_n = q.tx_n + 4'h1;
            if (q.tx_n == last_bit(q.sc.sm_hi, q.sc.sm_lo))
            begin
              n.tx_st = spu_pkg::TX_IDLE;
              ti_set = 1'b1;
            end
          end
          else
          begin
            n.tx_c = q.tx_c + 4'h1;
          end
        end
      end
      default: n.tx_st = spu_pkg::TX_IDLE;
    endcase
    // Receiver.
    case (q.rx_st)
      spu_pkg::RX_IDLE:
      begin
        if (q.sc.ren)
        begin
          n.rx_c = 4'h0;
          n.rx_n = 4'h0;
          n.rx_v = 3'h0;
          if (m0)
          begin
            if (!q.sc.ri && (q.tx_st == spu_pkg::TX_IDLE) && !pop)
            begin
              n.rx_st = spu_pkg::RX_SHIFT;
            end
          end
          else if (q.sync[2] && !rxd)
          begin
            n.rx_st = spu_pkg::RX_ASYNC;
          end
        end
      end
      spu_pkg::RX_SHIFT:
      begin
        n.rx_c = q.rx_c + 4'h1;
        if (q.rx_c == `SPU_M0_SAMP)
        begin
          n.rx_sh = {rxd, q.rx_sh[8:1]};
          n.rx_n = q.rx_n + 4'h1;
        end
        if (q.rx_c == `SPU_M0_LAST)
        begin
          n.rx_c = 4'h0;
          if (q.rx_n == `SPU_M0_BITS)
          begin
            n.rx_st = spu_pkg::RX_IDLE;
            rx_fin = 1'b1;
          end
        end
      end
      spu_pkg::RX_ASYNC:
      begin
        if (rtick)
        begin
          n.rx_c = q.rx_c + 4'h1;
          if ((q.rx_c >= `SPU_VOTE_LO) && (q.rx_c <= `SPU_VOTE_HI))
          begin
            n.rx_v = {q.rx_v[1:0], rxd};
          end
          if ((q.rx_c == `SPU_VOTE_CHK) && (q.rx_n == 4'h0) && rx_bit)
          begin
            n.rx_st = spu_pkg::RX_IDLE;
          end
          if (q.rx_c == `SPU_OVS_LAST)
          begin
            n.rx_c = 4'h0;
            n.rx_n = q.rx_n + 4'h1;
            if (q.rx_n == last_bit(q.sc.sm_hi, q.sc.sm_lo))
            begin
              n.rx_st = spu_pkg::RX_IDLE;
              rx_fin = 1'b1;
            end
            else if (q.rx_n != 4'h0)
            begin
              n.rx_sh = {rx_bit, q.rx_sh[8:1]};
            end
          end
        end
      end
      default: n.rx_st = spu_pkg::RX_IDLE;
    endcase
    // Frame completion and acceptance.
    if (rx_fin)
    begin
      if (m0)
      begin
        acc = 1'b1;
        rdat = q.rx_sh[8:1];
        r9 = q.sc.rb8;
      end
      else if (m1)
      begin
        acc = !q.sc.mp || rx_bit;
        rdat = q.rx_sh[8:1];
        r9 = rx_bit;
      end
      else
      begin
        acc = !q.sc.mp || q.rx_sh[8];
        rdat = q.rx_sh[7:0];
        r9 = q.rx_sh[8];
      end
      if (!m0 && !rx_bit)
      begin
        n.serial_error_flag = 1'b1;
      end
      if (acc)
      begin
        if (q.sc.ri && !m0)
        begin
          n.serial_error_flag = 1'b1;
        end
        else
        begin
          n.rbuf = rdat;
          n.sc.rb8 = r9;
          n.sc.ri = 1'b1;
        end
      end
    end
    if (ti_set)
    begin
      n.sc.ti = 1'b1;
    end
    n.irq = n.sc.ri || n.sc.ti;
    // Pin drivers.
    n.rxd_oe = m0 && (n.tx_st == spu_pkg::TX_RUN);
    n.rxd_o = n.rxd_oe ? n.tx_sh[0] : 1'b1;
    if (m0)
    begin
      if (n.tx_st == spu_pkg::TX_RUN)
      begin
        n.txd = (n.tx_c >= `SPU_M0_HALF);
      end
      else if (n.rx_st == spu_pkg::RX_SHIFT)
      begin
        n.txd = (n.rx_c >= `SPU_M0_HALF);
      end
      else
      begin
        n.txd = 1'b1;
      end
    end
    else
    begin
      n.txd = (n.tx_st == spu_pkg::TX_RUN) ? n.tx_sh[0] : 1'b1;
    end
    // Register reads.
    if (sfr_rd)
    begin
      case (sfr_addr)
        `SPU_CTL_ADR: n.rdata = q.sc;
        `SPU_BUF_ADR: n.rdata = q.rbuf;
        `SPU_T2C_ADR: n.rdata = {2'b00, q.rclk, q.tx_clock_select, 4'h0};
        `SPU_PWR_ADR: n.rdata = {q.rate_double, 7'h00};
        `SPU_IOC_ADR: n.rdata = {2'b00, q.serial_error_flag, 5'h00};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '{sc: `SPU_CTL_RST, rbuf: 8'h00, tx_clock_select: 1'b0, rclk: 1'b0, rate_double: 1'b0,
             serial_error_flag: 1'b0, rdata: 8'h00, irq: 1'b0, txd: 1'b1, rxd_o: 1'b1,
             rxd_oe: 1'b0, pre: 2'h0, half: 1'b0, sync: 3'h7,
             tx_st: spu_pkg::TX_IDLE, tx_sh: 11'h7FF, tx_n: 4'h0, tx_c: 4'h0,
             tx_b8: 1'b0, rx_st: spu_pkg::RX_IDLE, rx_sh: 9'h000, rx_n: 4'h0,
             rx_c: 4'h0, rx_v: 3'h0};
    end
    else
    begin
      q <= n;
    end
  end

  assign sfr_rdata = q.rdata;
  assign serial_irq = q.irq;
  assign txd = q.txd;
  assign rxd_out = q.rxd_o;
  assign rxd_oe = q.rxd_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  irq_or_a: assert property (serial_irq == (q.sc.ri || q.sc.ti))
    else $error("irq is not the OR of the done flags");
  ri_sw_clear_a: assert property ($fell(q.sc.ri) |-> $past(ctl_wr))
    else $error("receive flag cleared without software");
  ti_sw_clear_a: assert property ($fell(q.sc.ti) |-> $past(ctl_wr))
    else $error("transmit flag cleared without software");
  rx_enable_a: assert property (q.rx_st == spu_pkg::RX_IDLE && !q.sc.ren
    |=> q.rx_st == spu_pkg::RX_IDLE)
    else $error("reception started while disabled");
  shift_clk_a: assert property (m0 && q.tx_st == spu_pkg::TX_RUN && $fell(txd)
    |=> !txd [*5] ##1 txd)
    else $error("shift clock low phase is not six cycles");
  ninth_tx_a: assert property (q.tx_st == spu_pkg::TX_RUN && q.tx_n == 4'h9
    && q.sc.sm_hi |-> q.tx_sh[0] == q.tx_b8)
    else $error("ninth bit differs from the stored value");
  mp_nine_a: assert property (rx_fin && q.sc.sm_hi && q.sc.mp && !q.rx_sh[8]
    |=> $stable(q.rbuf))
    else $error("filtered frame reached the buffer");
  mp_stop_a: assert property (rx_fin && m1 && q.sc.mp && !rx_bit
    |=> $stable(q.rbuf))
    else $error("frame without stop bit reached the buffer");
  err_sticky_a: assert property ($fell(q.serial_error_flag) |-> $past(err_wr))
    else $error("error bit cleared without software");
  rbuf_load_a: assert property ($changed(q.rbuf) |-> $past(rx_fin) && q.sc.ri)
    else $error("receive buffer changed outside a frame");

  m1_rx_c: cover property (rx_fin && m1 ##1 q.sc.ri);
  m0_tx_c: cover property (m0 && q.tx_st == spu_pkg::TX_RUN ##1 $rose(q.sc.ti));
  ovr_c: cover property (rx_fin && q.sc.ri && !m0 ##1 $rose(q.serial_error_flag));
endmodule
`default_nettype wire

// >>> testbench/spu_peer.sv
// Purpose: Remote serial peer that sends frames and catches frames.
// Assumes: Bit times are given in clk_sys cycles.
// Notes: The peer drives its line high between frames.
`timescale 1ns/1ps
`default_nettype none
module spu_peer (
  input  wire logic clk_sys,
  input  wire logic txd,
  output logic      peer_line
);
  initial peer_line = 1'b1;
  ////////////////////////////////////////////////////////////
  // Sends n bits, bit 0 first, each p cycles long.
  task automatic send(input logic [10:0] f, input int n, input int p);
    for (int i = 0; i < n; i++)
    begin
      peer_line = f[i];
      repeat (p) @(negedge clk_sys);
    end
    peer_line = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////
  // Catches n bits at the bit centres after a start edge.
  task automatic catch(input int n, input int p, output logic [10:0] f, output bit ok);
    int k;
    f = 11'h000;
    for (k = 0; k < 4000 && txd !== 1'b0; k++)
      @(negedge clk_sys);
    ok = (k < 4000);
    repeat (p / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      if (i < n - 1)
        repeat (p) @(negedge clk_sys);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Shifts 8 bits out, bit 0 first, the next one after each rise of the shift clock.
  task automatic shift(input logic [7:0] d, output bit ok);
    logic [8:0] s;
    int         k;
    s = {1'b1, d};
    k = 0;
    peer_line = s[0];
    for (int i = 1; i <= 8 && k < 400; i++)
    begin
      for (; k < 400 && txd !== 1'b0; k++)
        @(negedge clk_sys);
      for (; k < 400 && txd !== 1'b1; k++)
        @(negedge clk_sys);
      peer_line = s[i];
    end
    ok = (k < 400);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench of the serial port.
// Assumes: Timer overflows are steady pulse trains made here.
// Notes: Bit times are counted in clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [7:0] bit_addr = 8'h00;
  logic       bit_wr = 1'b0;
  logic       bit_val = 1'b0;
  logic       t1_ovf = 1'b0;
  logic       t2_ovf = 1'b0;
  logic [1:0] t1_cnt = 2'h0;
  logic       peer_line;
  logic       rxd_line;
  logic       rxd_out;
  logic       rxd_oe;
  logic       txd;
  logic       serial_irq;
  logic       tx_ready;
  int         num_errors = 0;
  int         n_compared = 0;

  always #5 clk_sys = ~clk_sys;
  assign rxd_line = rxd_oe ? rxd_out : peer_line;
  always @(negedge clk_sys)
  begin
    t1_cnt <= (t1_cnt == 2'h2) ? 2'h0 : t1_cnt + 2'h1;
    t1_ovf <= (t1_cnt == 2'h2);
    t2_ovf <= ~t2_ovf;
  end
  spu_top uut (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .sfr_addr   (sfr_addr),
    .sfr_wr     (sfr_wr),
    .sfr_rd     (sfr_rd),
    .sfr_wdata  (sfr_wdata),
    .sfr_rdata  (sfr_rdata),
    .bit_addr   (bit_addr),
    .bit_wr     (bit_wr),
    .bit_val    (bit_val),
    .t1_ovf     (t1_ovf),
    .t2_ovf     (t2_ovf),
    .rxd_in     (rxd_line),
    .rxd_out    (rxd_out),
    .rxd_oe     (rxd_oe),
    .txd        (txd),
    .serial_irq (serial_irq),
    .tx_ready   (tx_ready)
  );
  spu_peer peer (
    .clk_sys   (clk_sys),
    .txd       (txd),
    .peer_line (peer_line)
  );
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bound_out;
    num_errors++;
    close_out();
  endtask
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    @(negedge clk_sys);
    d = sfr_rdata;
  endtask
  task automatic bw(input logic [7:0] a, input logic b);
    bit_addr = a;
    bit_val = b;
    bit_wr = 1'b1;
    @(negedge clk_sys);
    bit_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic waitf(input logic [7:0] m);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 400 && (v & m) !== m; k++)
      rd(8'h98, v);
    if ((v & m) !== m)
      bound_out();
  endtask
  task automatic rxc(input logic [7:0] c, input logic [10:0] f, input int n,
                     output logic [7:0] v);
    wr(8'h98, c);
    peer.send(f, n, 32);
    repeat (40) @(negedge clk_sys);
    rd(8'h98, v);
  endtask
  function automatic int bitp(input logic [1:0] m, input logic s, input logic d);
    if (m == 2'h2)
      return d ? 32 : 64;
    if (s)
      return 32;
    return d ? 48 : 96;
  endfunction
  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0]  v;
    logic [7:0]  td;
    logic [7:0]  rdv;
    logic [7:0]  w [3];
    logic [10:0] f;
    logic [10:0] g;
    logic [1:0]  m;
    logic        ts;
    logic        rs;
    logic        dbl;
    logic        b8;
    logic        r9;
    bit          ok;
    int          k;
    void'($urandom(70456));
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    chk("reset pins", 11'h003, {7'h00, serial_irq, rxd_oe, txd, tx_ready});
    rd(8'h98, v);
    chk("ctl reset", 11'h000, 11'(v));
    for (int i = 7; i >= 0; i--)
    begin
      bw(8'h98 + 8'(i), 1'b1);
      rd(8'h98, v);
      chk("ctl bits", 11'(8'(8'hFF << i)), 11'(v));
    end
    chk("irq set", 11'h001, 11'(serial_irq));
    wr(8'h98, 8'h00);
    rd(8'h98, v);
    chk("irq clear", 11'h000, 11'(serial_irq));
    bw(8'hCC, 1'b1);
    bw(8'hCD, 1'b1);
    rd(8'hC8, v);
    chk("clock select", 11'h030, 11'(v));
    wr(8'h87, 8'hFF);
    bw(8'h8F, 1'b0);
    rd(8'h87, v);
    chk("rate double", 11'h080, 11'(v));
    bw(8'hFD, 1'b1);
    rd(8'hF8, v);
    chk("error flag", 11'h020, 11'(v));
    wr(8'h9A, 8'hFF);
    rd(8'h9A, v);
    chk("unmapped", 11'h000, 11'(v));
    $display("test registers done");
    for (int c = 0; c < 12; c++)
    begin
      m = 2'(c / 4 + 1);
      ts = c[1];
      dbl = c[0];
      rs = 1'($urandom);
      b8 = 1'($urandom);
      r9 = 1'($urandom);
      td = 8'($urandom);
      rdv = 8'($urandom);
      f = (m == 2'h1) ? {2'b01, rdv, 1'b0} : {1'b1, r9, rdv, 1'b0};
      wr(8'h98, {m, 2'b01, b8, 3'b000});
      wr(8'hC8, {2'b00, rs, ts, 4'h0});
      wr(8'h87, {dbl, 7'h00});
      k = (m == 2'h1) ? 10 : 11;
      fork
        wr(8'h99, td);
        peer.catch(k, bitp(m, ts, dbl), g, ok);
        peer.send(f, k, bitp(m, rs, dbl));
      join
      if (!ok)
        bound_out();
      chk("tx frame", (m == 2'h1) ? {2'b01, td, 1'b0} : {1'b1, b8, td, 1'b0}, g);
      waitf(8'h03);
      rd(8'h98, v);
      chk("rx ninth", 11'((m == 2'h1) ? 1'b1 : r9), 11'(v[2]));
      chk("irq", 11'h001, 11'(serial_irq));
      rd(8'h99, v);
      chk("rx data", 11'(rdv), 11'(v));
    end
    $display("test duplex done");
    wr(8'hC8, 8'h30);
    wr(8'h87, 8'h00);
    bw(8'hFD, 1'b0);
    rxc(8'h40, {2'b01, 8'h5A, 1'b0}, 10, v);
    chk("rx disabled", 11'h040, 11'(v));
    rxc(8'hF0, {1'b1, 1'b0, 8'h3C, 1'b0}, 11, v);
    chk("filter drop", 11'h0F0, 11'(v));
    rxc(8'hF0, {1'b1, 1'b1, 8'hC3, 1'b0}, 11, v);
    chk("filter take", 11'h0F5, 11'(v));
    rd(8'h99, v);
    chk("filter data", 11'h0C3, 11'(v));
    rxc(8'h70, {2'b00, 8'h66, 1'b0}, 10, v);
    chk("stop drop", 11'h070, 11'(v));
    rd(8'hF8, v);
    chk("framing", 11'h020, 11'(v));
    bw(8'hFD, 1'b0);
    rd(8'hF8, v);
    chk("error clear", 11'h000, 11'(v));
    rxc(8'h50, {2'b00, 8'h99, 1'b0}, 10, v);
    chk("stop take", 11'h051, 11'(v));
    peer.send(11'h000, 1, 4);
    repeat (40) @(negedge clk_sys);
    rxc(8'h50, {2'b01, 8'h81, 1'b0}, 10, v);
    chk("after glitch", 11'h055, 11'(v));
    bw(8'hFD, 1'b0);
    peer.send({2'b01, 8'h18, 1'b0}, 10, 32);
    repeat (40) @(negedge clk_sys);
    rd(8'hF8, v);
    chk("overrun", 11'h020, 11'(v));
    rd(8'h99, v);
    chk("kept data", 11'h081, 11'(v));
    $display("test receive done");
    wr(8'h98, 8'h00);
    td = 8'($urandom);
    wr(8'h99, td);
    k = 0;
    for (int i = 0; i < 8; i++)
    begin
      for (k = 0; k < 100 && txd !== 1'b0; k++)
        @(negedge clk_sys);
      for (; k < 100 && txd !== 1'b1; k++)
        @(negedge clk_sys);
      if (k == 100)
        bound_out();
      g[i] = rxd_out;
      chk("pin drive", 11'h001, 11'(rxd_oe));
      if (i > 0)
        chk("shift period", 11'h00C, 11'(k));
    end
    chk("shift data", 11'(td), 11'(g[7:0]));
    waitf(8'h02);
    chk("pin free", 11'h000, 11'(rxd_oe));
    rdv = 8'($urandom);
    fork
      wr(8'h98, 8'h10);
      peer.shift(rdv, ok);
    join
    if (!ok)
      bound_out();
    waitf(8'h01);
    rd(8'h98, v);
    chk("shift flags", 11'h011, 11'(v));
    chk("shift idle", 11'h000, 11'(rxd_oe));
    rd(8'h99, v);
    chk("shift in", 11'(rdv), 11'(v));
    $display("test shift done");
    wr(8'h98, 8'h88);
    wr(8'h87, 8'h80);
    sfr_addr = 8'h99;
    sfr_wr = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      w[i] = 8'($urandom);
      sfr_wdata = w[i];
      @(negedge clk_sys);
    end
    sfr_wr = 1'b0;
    @(negedge clk_sys);
    chk("buffer full", 11'h000, 11'(tx_ready));
    for (int i = 0; i < 3; i++)
    begin
      peer.catch(11, 32, g, ok);
      if (!ok)
        bound_out();
      chk("queued frame", {2'b11, w[i], 1'b0}, g);
    end
    $display("test buffer done");
    close_out();
  end
endmodule
`default_nettype wire
